/* rtl/pwm_clock_prescale_and_irq_status.sv */
// PWM input clock prescaler and channel interrupt status flags
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - Divider field bits 2-0 pick divide by 1..64; code 111 is reserved.
// - Divider field comes out of reset as 000, clock passes undivided.
// - Divider bits 15-3 read zero and ignore writes.
// - Current-limit pending flag set by hardware on event while its enable bit 11 is set, else reads zero.
module pwm_clock_prescale_and_irq_status (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire pwm_prescale_pkg::reg_req_t req,
  output logic [15:0] rdata,
  input wire pwm_prescale_pkg::pwm_event_t events,
  input wire logic pwm_module_enable,
  output logic pwm_clock_enable,
  output logic irq
);
  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic [2:0] input_clock_prescale_select;
  logic [15:0] ctrl;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] pend;
  logic [2:0] ev_vec;
  logic [2:0] en_vec;
  logic [5:0] div_cnt;
  wire wr_div = req.wr && req.addr == pwm_prescale_pkg::OFS_CLOCK_DIVIDER;
  wire wr_ctrl = req.wr && req.addr == pwm_prescale_pkg::OFS_CHANNEL_CONTROL;
  wire wr_stat = req.wr && req.addr == pwm_prescale_pkg::OFS_IRQ_STATUS;
  wire wr_mask = req.wr && req.addr == pwm_prescale_pkg::OFS_IRQ_MASK;
  wire [15:0] ctrl_view = {pend, ctrl[12:0]};
  // Upper bits of the divider register are not stored at all
  wire [15:0] div_view = {13'h0000, input_clock_prescale_select};
  wire [15:0] next_rdata =
    req.addr == pwm_prescale_pkg::OFS_CLOCK_DIVIDER ? div_view :
    req.addr == pwm_prescale_pkg::OFS_CHANNEL_CONTROL ? ctrl_view :
    req.addr == pwm_prescale_pkg::OFS_IRQ_STATUS ? {13'h0000, irq_status} :
    req.addr == pwm_prescale_pkg::OFS_IRQ_MASK ? {13'h0000, irq_mask} :
    16'h0000;

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      rdata <= 16'h0000;
    else if (req.rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn)
      input_clock_prescale_select <= pwm_prescale_pkg::PRESCALE_RESET;
    else if (wr_div)
      input_clock_prescale_select <= req.wdata[2:0];
  end

  // Terminal count per code; reserved code holds the enable low
  wire [5:0] div_last = 6'((7'h01 << input_clock_prescale_select) - 7'h01);
  wire div_reserved =
    input_clock_prescale_select == pwm_prescale_pkg::PRESCALE_RESERVED;
  wire div_hit = div_cnt >= div_last;

  // Counter runs only with the module enabled, so a change made while
  // stopped always starts cleanly; a change while running is unsafe
  always_ff @(posedge ref_clk) begin
    if (!resetn || !pwm_module_enable || div_reserved)
      div_cnt <= 6'h00;
    else if (div_hit)
      div_cnt <= 6'h00;
    else
      div_cnt <= div_cnt + 6'h01;
  end

  assign pwm_clock_enable = pwm_module_enable && !div_reserved && div_hit;

  // ------------------------------------------------------------
  // Channel control and pending flags
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn)
      ctrl <= pwm_prescale_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= req.wdata & pwm_prescale_pkg::CTRL_RW_MASK;
  end

  assign ev_vec = {events.trigger, events.current_limit, events.fault};
  assign en_vec = {ctrl[pwm_prescale_pkg::TRIG_EN_BIT],
                   ctrl[pwm_prescale_pkg::CLIM_EN_BIT],
                   ctrl[pwm_prescale_pkg::FAULT_EN_BIT]};

  logic [2:0] p;
  genvar i;
  generate
    for (i = 0; i < pwm_prescale_pkg::EV_N; i++) begin : g_flag
      // Flag only pends while its enable is set; enable low clears it
      always_ff @(posedge ref_clk) begin
        if (!resetn)
          p[i] <= 1'b0;
        else if (!en_vec[i])
          p[i] <= 1'b0;
        else if (ev_vec[i])
          p[i] <= 1'b1;
      end
      // Sticky status: a new event wins over a write-one clear
      always_ff @(posedge ref_clk) begin
        if (!resetn)
          irq_status[i] <= 1'b0;
        else if (ev_vec[i] && en_vec[i])
          irq_status[i] <= 1'b1;
        else if (wr_stat && req.wdata[i])
          irq_status[i] <= 1'b0;
      end
    end
  endgenerate
  // Control view order is fault, current-limit, trigger from bit 15 down
  assign pend = {p[pwm_prescale_pkg::EV_FAULT], p[pwm_prescale_pkg::EV_CLIM],
                 p[pwm_prescale_pkg::EV_TRIG]};

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      irq_mask <= pwm_prescale_pkg::EV_RESET;
    else if (wr_mask)
      irq_mask <= req.wdata[2:0];
  end

  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Cycles since the last enable pulse; cleared whenever the run stops,
  // so only a full period between two pulses is ever measured
  logic [6:0] pulse_gap;
  logic gap_valid;
  always_ff @(posedge ref_clk) begin
    if (!resetn || !pwm_module_enable || wr_div) begin
      pulse_gap <= 7'h00;
      gap_valid <= 1'b0;
    end else if (pwm_clock_enable) begin
      pulse_gap <= 7'h01;
      gap_valid <= 1'b1;
    end else begin
      pulse_gap <= pulse_gap + 7'h01;
    end
  end

  a_div_reads_zero: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    $past(req.rd) && $past(req.addr) == pwm_prescale_pkg::OFS_CLOCK_DIVIDER
    |-> rdata[15:3] == 13'h0000)
    else $error("divider upper bits not zero");
  a_div_reset_code: assert property (@(posedge ref_clk)
    $past(!resetn)
    |-> input_clock_prescale_select == pwm_prescale_pkg::PRESCALE_RESET)
    else $error("prescale select not zero after reset");
  a_div_by_two: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pwm_clock_enable && input_clock_prescale_select == 3'h1
    && $stable(input_clock_prescale_select) ##1
    $stable(input_clock_prescale_select) && pwm_module_enable
    |-> !pwm_clock_enable)
    else $error("divide by two enable too fast");
  a_div_reserved_off: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    input_clock_prescale_select == pwm_prescale_pkg::PRESCALE_RESERVED
    |-> !pwm_clock_enable)
    else $error("reserved code produced enable");
  a_div_period: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pwm_clock_enable && gap_valid
    |-> pulse_gap == (7'h01 << input_clock_prescale_select))
    else $error("enable pulse period does not match select code");
  a_div_by_one: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pwm_module_enable
    && input_clock_prescale_select == pwm_prescale_pkg::PRESCALE_RESET
    |-> pwm_clock_enable)
    else $error("undivided clock enable missing");
  a_div_write_lands: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    wr_div |=> input_clock_prescale_select
      == $past(req.wdata[pwm_prescale_pkg::PRESCALE_W-1:0]))
    else $error("prescale select write lost");
  a_div_holds: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !wr_div |=> $stable(input_clock_prescale_select))
    else $error("prescale select changed without a write");
  a_clim_sets: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    events.current_limit && ctrl[pwm_prescale_pkg::CLIM_EN_BIT]
    |=> ctrl_view[pwm_prescale_pkg::CLIM_PEND_BIT])
    else $error("current-limit flag not set");
  a_clim_quiet: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !ctrl_view[pwm_prescale_pkg::CLIM_PEND_BIT] && !events.current_limit
    |=> !ctrl_view[pwm_prescale_pkg::CLIM_PEND_BIT])
    else $error("current-limit flag set with no event");
  a_clim_clears: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !ctrl[pwm_prescale_pkg::CLIM_EN_BIT]
    |=> !ctrl_view[pwm_prescale_pkg::CLIM_PEND_BIT])
    else $error("current-limit flag held with enable low");
  a_fault_sets: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    events.fault && ctrl[pwm_prescale_pkg::FAULT_EN_BIT]
    |=> ctrl_view[pwm_prescale_pkg::FAULT_PEND_BIT])
    else $error("fault flag not set");
  a_fault_clears: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !ctrl[pwm_prescale_pkg::FAULT_EN_BIT]
    |=> !ctrl_view[pwm_prescale_pkg::FAULT_PEND_BIT])
    else $error("fault flag held with enable low");
  a_trig_sets: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    events.trigger && ctrl[pwm_prescale_pkg::TRIG_EN_BIT]
    |=> ctrl_view[pwm_prescale_pkg::TRIG_PEND_BIT])
    else $error("trigger flag not set");
  a_trig_clears: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    $fell(ctrl[pwm_prescale_pkg::TRIG_EN_BIT])
    |=> !ctrl_view[pwm_prescale_pkg::TRIG_PEND_BIT])
    else $error("trigger flag held after enable cleared");
  a_status_sticky: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    irq_status[pwm_prescale_pkg::EV_CLIM]
    && !(wr_stat && req.wdata[pwm_prescale_pkg::EV_CLIM])
    |=> irq_status[pwm_prescale_pkg::EV_CLIM])
    else $error("current-limit status lost without a clear");
  a_irq_level: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    events.fault && ctrl[pwm_prescale_pkg::FAULT_EN_BIT]
    && irq_mask[pwm_prescale_pkg::EV_FAULT] && !wr_mask |=> irq [*1])
    else $error("interrupt missing after masked-in event");
endmodule : pwm_clock_prescale_and_irq_status

/* rtl/pwm_prescale_pkg.sv */
// Package: register map, field layout and types for the PWM prescaler block
package pwm_prescale_pkg;
  localparam int ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] OFS_CLOCK_DIVIDER = 4'h0;
  localparam logic [3:0] OFS_CHANNEL_CONTROL = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
  // Divider register fields
  localparam int PRESCALE_W = 3;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [2:0] PRESCALE_RESERVED = 3'h7;
  localparam int PRESCALE_CNT_W = 6;
  // Channel control fields
  localparam int FAULT_PEND_BIT = 15;
  localparam int CLIM_PEND_BIT = 14;
  localparam int TRIG_PEND_BIT = 13;
  localparam int FAULT_EN_BIT = 12;
  localparam int CLIM_EN_BIT = 11;
  localparam int TRIG_EN_BIT = 10;
  localparam logic [15:0] CTRL_RW_MASK = 16'h1FEF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Event index layout of status and mask
  localparam int EV_FAULT = 0;
  localparam int EV_CLIM = 1;
  localparam int EV_TRIG = 2;
  localparam int EV_N = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic fault;
    logic current_limit;
    logic trigger;
  } pwm_event_t;
endpackage : pwm_prescale_pkg

/* testbench/pwm_clock_prescale_and_irq_status_tb.sv */
// Self-checking bench for the PWM prescaler and interrupt flag block
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module pwm_clock_prescale_and_irq_status_tb;
  logic ref_clk, resetn, pwm_module_enable, pwm_clock_enable, irq;
  pwm_prescale_pkg::reg_req_t req;
  pwm_prescale_pkg::pwm_event_t events;
  logic [15:0] rdata;
  int fails, samples_checked, pulses;

  pwm_clock_prescale_and_irq_status i_pwm_clock_prescale_and_irq_status (
    .ref_clk(ref_clk), .resetn(resetn), .req(req), .rdata(rdata),
    .events(events), .pwm_module_enable(pwm_module_enable),
    .pwm_clock_enable(pwm_clock_enable), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task rd(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask : rd

  task ev(input logic [2:0] e);
    @(posedge ref_clk);
    events <= e;
    @(posedge ref_clk);
    events <= 3'h0;
  endtask : ev

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    samples_checked = 0;
    resetn = 1'b0;
    pwm_module_enable = 1'b0;
    events = 3'h0;
    req = '0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd("divider", pwm_prescale_pkg::OFS_CLOCK_DIVIDER, 16'h0000);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h0000);
    rd("status", pwm_prescale_pkg::OFS_IRQ_STATUS, 16'h0000);
    rd("unmapped", 4'h2, 16'h0000);
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
    wr(pwm_prescale_pkg::OFS_CLOCK_DIVIDER, 16'hFFFE);
    rd("divider", pwm_prescale_pkg::OFS_CLOCK_DIVIDER, 16'h0006);
    wr(pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'hFFFF);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h1FEF);
    wr(pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h0000);
    $display("test registers done");
    // Enable drops after each code, so every code starts from a cleared count
    for (int c = 0; c < 8; c++) begin
      wr(pwm_prescale_pkg::OFS_CLOCK_DIVIDER, 16'(c));
      pwm_module_enable <= 1'b1;
      repeat (64) @(posedge ref_clk);
      pulses = 0;
      repeat (128) begin
        @(posedge ref_clk);
        pulses += int'(pwm_clock_enable === 1'b1);
      end
      pwm_module_enable <= 1'b0;
      `CHK("pulses", (c == 7) ? 0 : (128 >> c), pulses)
    end
    $display("test prescaler done");
    wr(pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h1C00);
    wr(pwm_prescale_pkg::OFS_IRQ_MASK, 16'h0007);
    ev(3'h7);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'hFC00);
    rd("status", pwm_prescale_pkg::OFS_IRQ_STATUS, 16'h0007);
    `CHK("irq", 1'b1, irq)
    wr(pwm_prescale_pkg::OFS_IRQ_STATUS, 16'h0007);
    rd("status", pwm_prescale_pkg::OFS_IRQ_STATUS, 16'h0000);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'hFC00);
    `CHK("irq", 1'b0, irq)
    wr(pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h0000);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h0000);
    ev(3'h7);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h0000);
    wr(pwm_prescale_pkg::OFS_IRQ_STATUS, 16'h0007);
    wr(pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h1C00);
    wr(pwm_prescale_pkg::OFS_IRQ_MASK, 16'h0000);
    ev(3'h2);
    rd("control", pwm_prescale_pkg::OFS_CHANNEL_CONTROL, 16'h5C00);
    `CHK("irq", 1'b0, irq)
    wr(pwm_prescale_pkg::OFS_IRQ_MASK, 16'h0002);
    #1;
    `CHK("irq", 1'b1, irq)
    $display("test interrupts done");
    finish_test();
  end
endmodule : pwm_clock_prescale_and_irq_status_tb
